// ### design/ddl_pkg.sv
/*
 * constants, field layouts and carriers for the dither, offset delay and
 * line-loss configuration bank.
 * assumes an 8-bit register port and a 100 MHz system clock.
 */
package ddl_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DITHER_CFG = 8'h5D;
    localparam logic [7:0] ADDR_OFS_LL_CFG = 8'h5E;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h60;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h61;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h62;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         POS_NODIM_ONLY  = 7;
    localparam int         POS_DIT_LVL     = 5;
    localparam int         POS_DIT_CHAN    = 4;
    localparam int         POS_CH2_OFS     = 5;
    localparam int         POS_CH1_OFS     = 2;
    localparam int         POS_LL_THR      = 0;
    localparam logic [7:0] RST_DITHER_CFG  = 8'h00;
    localparam logic [7:0] RST_OFS_LL_CFG  = 8'h00;
    localparam logic [1:0] RST_IRQ         = 2'h0;
    localparam logic [7:0] DIT_CFG_MASK    = 8'hF0;
    localparam int         IRQ_LINE_LOSS   = 0;
    localparam int         IRQ_CFG_WRITE   = 1;

    // ------------------------------------------------------------
    // timing: offset compensation step
    // ------------------------------------------------------------
    localparam int OFS_STEP_NS = 50;
    localparam int CLK_PER_NS  = 10;
    localparam int OFS_STEP_CYC = (OFS_STEP_NS + CLK_PER_NS - 1) / CLK_PER_NS;

    // ------------------------------------------------------------
    // lookup tables: dither in tenths of a percent, thresholds in volts
    // ------------------------------------------------------------
    localparam logic [7:0] DIT_PCT_X10 [0:3] = '{8'h0D, 8'h1D, 8'h3C, 8'h7B};
    localparam logic [7:0] LL_THR_120V [0:3] = '{8'h50, 8'h28, 8'h14, 8'h0A};
    localparam logic [7:0] LL_THR_230V [0:3] = '{8'hA0, 8'h50, 8'h28, 8'h14};

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ddl_req_s;

    typedef struct packed {
        logic       dither_active;
        logic [1:0] dither_level_sel;
        logic [7:0] dither_pct_x10;
        logic       reduced_dither_channel_sel;
        logic [2:0] dither_attenuation_sel;
        logic [5:0] chan1_offset_cyc;
        logic [5:0] chan2_offset_cyc;
        logic [7:0] line_loss_thr_volts;
    } ddl_settings_s;
endpackage

// ### design/ddl_config.sv
/*
 * dither, timing offset and line-loss configuration bank with decode,
 * line-loss comparator and interrupt status.
 * assumes a single-cycle master on the register port, voltage codes from
 * logic on sys_clk, and an asynchronous part-variant strap pin.
 */
// What this block does
// - dithering applies in all modes when bit 7 is 0, no-dimmer only if 1
// - level field bits 6:5 pick 1.3, 2.9, 6 or 12.3 percent variation
// - bit 4 picks channel with reduced dither: 0 channel 1, 1 channel 2
// - 3-bit offsets, ch2 bits 7:5, ch1 bits 4:2, each step 50 ns
// - line-loss fault when boost below line by threshold; 120V: 80/40/20/10
// - for 230V parts, threshold codes select 160, 80, 40 and 20 volts
`timescale 1ns/10ps
module ddl_config #(
    parameter int VW = 9
) (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire ddl_pkg::ddl_req_s      req,
    output logic [7:0]                  rd_data,
    input  wire logic                   dither_enable,
    input  wire logic                   nodimmer_mode,
    input  wire logic [1:0]             dither_attenuation_sel,
    input  wire logic                   part_230v_pin,
    input  wire logic [VW-1:0]          line_volts,
    input  wire logic [VW-1:0]          boost_volts,
    output ddl_pkg::ddl_settings_s      settings,
    output logic                        line_loss_fault,
    output logic                        irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]            dither_config;
    logic [7:0]            offset_delay_line_loss_config;
    logic [1:0]            irq_status;
    logic [1:0]            irq_enable;
    logic [7:0]            next_dither_config;
    logic [7:0]            next_ofs_ll;
    logic [1:0]            next_irq_status;
    logic [1:0]            next_irq_enable;
    logic [7:0]            next_rd_data;
    logic                  next_irq;
    logic                  strap_meta;
    logic                  part_230v;
    ddl_pkg::ddl_settings_s next_settings;
    logic                  next_fault;
    logic [VW:0]           drop;
    logic [1:0]            events;

    // ------------------------------------------------------------
    // strap synchroniser
    // ------------------------------------------------------------
    // two stages before the variant select is trusted
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strap_meta <= 1'b0;
            part_230v  <= 1'b0;
        end else begin
            strap_meta <= part_230v_pin;
            part_230v  <= strap_meta;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // writes, set-over-clear status, read mux
    always_comb begin
        next_dither_config = dither_config;
        next_ofs_ll        = offset_delay_line_loss_config;
        next_irq_enable    = irq_enable;
        next_irq_status    = irq_status;
        next_rd_data       = 8'h00;
        if (req.wr) begin
            case (req.addr)
                ddl_pkg::ADDR_DITHER_CFG: begin
                    // low nibble never stored
                    next_dither_config = req.wdata & ddl_pkg::DIT_CFG_MASK;
                end
                ddl_pkg::ADDR_OFS_LL_CFG: begin
                    next_ofs_ll = req.wdata;
                end
                ddl_pkg::ADDR_IRQ_CLEAR: begin
                    next_irq_status = irq_status & ~req.wdata[1:0];
                end
                ddl_pkg::ADDR_IRQ_ENABLE: begin
                    next_irq_enable = req.wdata[1:0];
                end
                default: begin
                    next_irq_status = irq_status;
                end
            endcase
        end
        next_irq_status = next_irq_status | events; // set wins
        if (req.rd) begin
            case (req.addr)
                ddl_pkg::ADDR_DITHER_CFG: next_rd_data = dither_config;
                ddl_pkg::ADDR_OFS_LL_CFG: begin
                    next_rd_data = offset_delay_line_loss_config;
                end
                ddl_pkg::ADDR_IRQ_STATUS: next_rd_data = {6'h00, irq_status};
                ddl_pkg::ADDR_IRQ_ENABLE: next_rd_data = {6'h00, irq_enable};
                default:                  next_rd_data = 8'h00;
            endcase
        end
        next_irq = |(next_irq_status & next_irq_enable);
    end

    // registers the bank
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dither_config                 <= ddl_pkg::RST_DITHER_CFG;
            offset_delay_line_loss_config <= ddl_pkg::RST_OFS_LL_CFG;
            irq_status                    <= ddl_pkg::RST_IRQ;
            irq_enable                    <= ddl_pkg::RST_IRQ;
            rd_data                       <= 8'h00;
            irq                           <= 1'b0;
        end else begin
            dither_config                 <= next_dither_config;
            offset_delay_line_loss_config <= next_ofs_ll;
            irq_status                    <= next_irq_status;
            irq_enable                    <= next_irq_enable;
            rd_data                       <= next_rd_data;
            irq                           <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // field decode and line-loss comparator
    // ------------------------------------------------------------
    // settings derived from the stored fields, the dither enable and mode inputs, the attenuation input and the strap
    always_comb begin
        logic [1:0] lvl;
        logic [1:0] thr;
        lvl = dither_config[ddl_pkg::POS_DIT_LVL +: 2];
        thr = offset_delay_line_loss_config[ddl_pkg::POS_LL_THR +: 2];
        next_settings.dither_active = dither_enable &&
            (!dither_config[ddl_pkg::POS_NODIM_ONLY] || nodimmer_mode);
        next_settings.dither_level_sel = lvl;
        next_settings.dither_pct_x10   = ddl_pkg::DIT_PCT_X10[lvl];
        next_settings.reduced_dither_channel_sel =
            dither_config[ddl_pkg::POS_DIT_CHAN];
        next_settings.dither_attenuation_sel = {1'b0, dither_attenuation_sel};
        next_settings.chan1_offset_cyc = 6'(
            offset_delay_line_loss_config[ddl_pkg::POS_CH1_OFS +: 3]
            * ddl_pkg::OFS_STEP_CYC);
        next_settings.chan2_offset_cyc = 6'(
            offset_delay_line_loss_config[ddl_pkg::POS_CH2_OFS +: 3]
            * ddl_pkg::OFS_STEP_CYC);
        next_settings.line_loss_thr_volts = part_230v ?
            ddl_pkg::LL_THR_230V[thr] :
            ddl_pkg::LL_THR_120V[thr];
        drop = {1'b0, line_volts} - {1'b0, boost_volts};
        next_fault = (line_volts > boost_volts) &&
            (drop >= (VW+1)'(next_settings.line_loss_thr_volts));
        events = 2'h0;
        events[ddl_pkg::IRQ_LINE_LOSS] = next_fault && !line_loss_fault;
        events[ddl_pkg::IRQ_CFG_WRITE] = req.wr &&
            (req.addr == ddl_pkg::ADDR_DITHER_CFG ||
             req.addr == ddl_pkg::ADDR_OFS_LL_CFG);
    end

    // registers the decoded outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            settings        <= '0;
            line_loss_fault <= 1'b0;
        end else begin
            settings        <= next_settings;
            line_loss_fault <= next_fault;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_dither_write;
        req.wr && req.addr == ddl_pkg::ADDR_DITHER_CFG;
    endsequence

    sequence s_dither_read;
        req.rd && !req.wr && req.addr == ddl_pkg::ADDR_DITHER_CFG;
    endsequence

    a_dither_mode_gate: assert property (
        s_dither_write ##1 (!req.wr && dither_enable && !nodimmer_mode)
        |=> settings.dither_active == !dither_config[7])
        else $error("dither gating by no-dimmer bit wrong");

    a_dither_level_pct: assert property (
        !$past(sys_rst) |-> settings.dither_pct_x10 ==
        ($past(dither_config[6:5]) == 2'h0 ? 8'h0D :
         $past(dither_config[6:5]) == 2'h1 ? 8'h1D :
         $past(dither_config[6:5]) == 2'h2 ? 8'h3C : 8'h7B))
        else $error("dither percentage does not match level");

    a_reduced_chan_sel: assert property (
        s_dither_write |-> ##2
        settings.reduced_dither_channel_sel == $past(req.wdata[4], 2))
        else $error("reduced dither channel not taken from bit 4");

    a_chan_offset_step: assert property (
        req.wr && req.addr == ddl_pkg::ADDR_OFS_LL_CFG |-> ##2
        (settings.chan2_offset_cyc == 6'($past(req.wdata[7:5], 2) * 5) &&
         settings.chan1_offset_cyc == 6'($past(req.wdata[4:2], 2) * 5)))
        else $error("channel offset not field times 50 ns");

    a_thr_120v_map: assert property (
        !$past(sys_rst) && !$past(part_230v)
        |-> settings.line_loss_thr_volts ==
        (8'h50 >> $past(offset_delay_line_loss_config[1:0])))
        else $error("120V threshold decode wrong");

    a_thr_230v_map: assert property (
        !$past(sys_rst) && $past(part_230v)
        |-> settings.line_loss_thr_volts ==
        (8'hA0 >> $past(offset_delay_line_loss_config[1:0])))
        else $error("230V threshold decode wrong");

    a_fault_raise: assert property (
        ({1'b0, line_volts} >= {1'b0, boost_volts} +
         (VW+1)'(next_settings.line_loss_thr_volts)) |=> line_loss_fault)
        else $error("line-loss fault missed");

    a_reserved_zero: assert property (
        s_dither_read |=> rd_data[3:0] == 4'h0)
        else $error("reserved dither bits read nonzero");

    // ------------------------------------------------------------
    // interrupt, read-port, strap, stored-bit, fault-clear and dither-off checks
    // ------------------------------------------------------------
    // a write to either configuration register
    sequence s_cfg_write;
        req.wr && (req.addr == ddl_pkg::ADDR_DITHER_CFG ||
                   req.addr == ddl_pkg::ADDR_OFS_LL_CFG);
    endsequence

    // a clear write with no event in the same cycle
    sequence s_clear_write;
        (req.wr && req.addr == ddl_pkg::ADDR_IRQ_CLEAR) ##0 (events == 2'h0);
    endsequence

    a_cfg_write_event: assert property (
        s_cfg_write |=> irq_status[ddl_pkg::IRQ_CFG_WRITE])
        else $error("configuration write left no status bit");

    a_line_loss_event: assert property (
        $rose(line_loss_fault) |-> irq_status[ddl_pkg::IRQ_LINE_LOSS])
        else $error("line-loss fault left no status bit");

    a_status_sticky: assert property (
        !(req.wr && req.addr == ddl_pkg::ADDR_IRQ_CLEAR)
        |=> (irq_status & $past(irq_status)) == $past(irq_status))
        else $error("status bit fell without a clear write");

    a_clear_bits: assert property (
        s_clear_write |=> (irq_status & $past(req.wdata[1:0])) == 2'h0)
        else $error("clear write left a status bit set");

    a_irq_level: assert property (
        irq == |(irq_status & irq_enable))
        else $error("interrupt line disagrees with status and enable");

    a_rd_idle_zero: assert property (
        !req.rd |=> rd_data == 8'h00)
        else $error("read data not zero outside a read answer");

    a_status_read: assert property (
        req.rd && req.addr == ddl_pkg::ADDR_IRQ_STATUS
        |=> rd_data == {6'h00, $past(irq_status)})
        else $error("status read returned wrong bits");

    a_ofs_readback: assert property (
        req.rd && req.addr == ddl_pkg::ADDR_OFS_LL_CFG
        |=> rd_data == $past(offset_delay_line_loss_config))
        else $error("offset and threshold register read back wrong");

    a_reserved_stored: assert property (
        dither_config[3:0] == 4'h0)
        else $error("reserved dither bits were stored");

    a_fault_clear: assert property (
        {1'b0, line_volts} < {1'b0, boost_volts} +
        (VW+1)'(next_settings.line_loss_thr_volts) |=> !line_loss_fault)
        else $error("line-loss fault raised below threshold");

    a_strap_sync: assert property (
        !$past(sys_rst) && !$past(sys_rst, 2)
        |-> part_230v == $past(part_230v_pin, 2))
        else $error("variant strap not taken through two stages");

    a_dither_off: assert property (
        !$past(sys_rst) && !$past(dither_enable)
        |-> !settings.dither_active)
        else $error("dithering active while disabled");
endmodule

// ### verification/tb_top.sv
/*
 * self-checking bench for the dither, offset and line-loss bank: register
 * access, decoded settings, line-loss fault and interrupt behaviour.
 * assumes ddl_config and ddl_pkg as declared, one 100 MHz clock.
 */
`timescale 1ns/10ps
module tb_top;
    logic                   sys_clk;
    logic                   sys_rst;
    ddl_pkg::ddl_req_s      req;
    logic [7:0]             rd_data;
    logic                   dither_enable;
    logic                   nodimmer_mode;
    logic [1:0]             att;
    logic                   part_230v_pin;
    logic [8:0]             line_volts;
    logic [8:0]             boost_volts;
    ddl_pkg::ddl_settings_s settings;
    logic                   line_loss_fault;
    logic                   irq;
    int                     bad_count;
    int                     compares;
    int                     cycles;
    logic [7:0]             d;
    logic [7:0]             cfg;
    logic [7:0]             ofs;
    logic [7:0]             thr;

    ddl_config u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
        .rd_data(rd_data), .dither_enable(dither_enable),
        .nodimmer_mode(nodimmer_mode), .dither_attenuation_sel(att),
        .part_230v_pin(part_230v_pin), .line_volts(line_volts),
        .boost_volts(boost_volts), .settings(settings),
        .line_loss_fault(line_loss_fault), .irq(irq));

    // ----------------------------------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------------------------------
    // free-running system clock
    always #5 sys_clk = ~sys_clk;

    // cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge sys_clk);
        req <= '0;
    endtask

    // read data stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        req <= '0;
        #1 v = rd_data;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // expected decode of both registers and the side inputs
    function automatic ddl_pkg::ddl_settings_s exp_set(input logic [7:0] c,
        input logic [7:0] o, input logic en, input logic nd,
        input logic [1:0] at, input logic v230);
        ddl_pkg::ddl_settings_s s;
        s.dither_active = en & (~c[7] | nd);
        s.dither_level_sel = c[6:5];
        case (c[6:5])
            2'h0: s.dither_pct_x10 = 8'h0D;
            2'h1: s.dither_pct_x10 = 8'h1D;
            2'h2: s.dither_pct_x10 = 8'h3C;
            default: s.dither_pct_x10 = 8'h7B;
        endcase
        s.reduced_dither_channel_sel = c[4];
        s.dither_attenuation_sel = {1'b0, at};
        s.chan1_offset_cyc = 6'(o[4:2]) * 6'h05;
        s.chan2_offset_cyc = 6'(o[7:5]) * 6'h05;
        s.line_loss_thr_volts = (v230 ? 8'hA0 : 8'h50) >> o[1:0];
        return s;
    endfunction

    task automatic results;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 0;
        sys_rst = 1;
        req = '0;
        {dither_enable, nodimmer_mode, att, part_230v_pin} = '0;
        line_volts = '0;
        boost_volts = '0;
        void'($urandom(35));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 0;
        tick(1);
        chk(64'(settings), 64'(exp_set(8'h00, 8'h00, 0, 0, 2'h0, 0)));
        // reserved nibble, status write and unmapped address
        wr(8'h5D, 8'hFF);
        wr(8'h60, 8'hFF);
        wr(8'h7F, 8'h5A);
        rd(8'h5D, d); chk(d, 8'hF0);
        rd(8'h7F, d); chk(d, 8'h00);
        rd(8'h61, d); chk(d, 8'h00);
        // config write event: masked, enabled, cleared
        wr(8'h61, 8'h03);
        rd(8'h60, d); chk(d, 8'h00);
        wr(8'h5D, 8'hA0);
        rd(8'h60, d); chk(d, 8'h02);
        chk(irq, 1'b0);
        wr(8'h62, 8'h02); tick(1); chk(irq, 1'b1);
        wr(8'h61, 8'h02); tick(1); chk(irq, 1'b0);
        rd(8'h60, d); chk(d, 8'h00);
        // random configurations with corners first
        for (int i = 0; i < 40; i++) begin
            cfg = (i == 0) ? 8'hFF : (i == 1) ? 8'h0F : 8'($urandom);
            ofs = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            @(posedge sys_clk);
            dither_enable <= (i < 2) ? 1'b1 : 1'($urandom);
            nodimmer_mode <= (i == 0) ? 1'b0 : 1'($urandom);
            att <= 2'($urandom);
            part_230v_pin <= 1'($urandom);
            wr(8'h5D, cfg);
            wr(8'h5E, ofs);
            tick(4);
            chk(64'(settings), 64'(exp_set(cfg, ofs, dither_enable,
                nodimmer_mode, att, part_230v_pin)));
            rd(8'h5D, d); chk(d, cfg & 8'hF0);
            rd(8'h5E, d); chk(d, ofs);
        end
        // line-loss thresholds at the boundary, both part variants
        wr(8'h62, 8'h01);
        wr(8'h61, 8'h03);
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            part_230v_pin <= k[2];
            wr(8'h5E, 8'(k[1:0]));
            thr = (k[2] ? 8'hA0 : 8'h50) >> k[1:0];
            line_volts <= 9'h12C;
            boost_volts <= 9'h12C - 9'(thr);
            tick(4);
            chk(settings.line_loss_thr_volts, thr);
            chk(line_loss_fault, 1'b1);
            chk(irq, 1'b1);
            @(posedge sys_clk);
            boost_volts <= 9'h12D - 9'(thr);
            tick(3);
            chk(line_loss_fault, 1'b0);
            wr(8'h61, 8'h03);
            tick(1);
            chk(irq, 1'b0);
        end
        // mid-run reset returns the bank to its reset state
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(8'h5E, d);
        chk(d, 8'h00);
        rd(8'h5D, d);
        chk(d, 8'h00);
        rd(8'h60, d);
        chk(d, 8'h00);
        chk(64'(settings), 64'(exp_set(8'h00, 8'h00, dither_enable,
            nodimmer_mode, att, part_230v_pin)));
        chk(line_loss_fault, 1'b0);
        chk(irq, 1'b0);
        results();
    end
endmodule
